// File: inc/sdss_params.svh
// Purpose: constants of the stepper drive and sync start block
// Assumes: hclk at 10 MHz, times held in ns, counts derived from them
// Notes: register offsets are byte addresses on the AHB-Lite slave
`ifndef SDSS_PARAMS_SVH
`define SDSS_PARAMS_SVH
`define SDSS_CLK_NS       100
`define SDSS_CYC(t)       (((t) + `SDSS_CLK_NS - 1) / `SDSS_CLK_NS)
`define SDSS_T_12U_NS     12000
`define SDSS_T_102U_NS    102000
`define SDSS_T_409U_NS    409000
`define SDSS_T_1M6_NS     1600000
`define SDSS_T_13M_NS     13000000
`define SDSS_T_52M_NS     52000000
`define SDSS_T_104M_NS    104000000
`define SDSS_T_208M_NS    208000000
`define SDSS_T_416M_NS    416000000
`define SDSS_T_832M_NS    832000000
`define SDSS_T_FLT_S_NS   500
`define SDSS_T_FLT_L_NS   40000000
`define SDSS_SHOT_CYC     4'h8
`define SDSS_OFF_ENV1     8'h00
`define SDSS_OFF_ENV2     8'h04
`define SDSS_OFF_MODE     8'h08
`define SDSS_OFF_STAT     8'h0C
`define SDSS_OFF_IRQ      8'h10
`define SDSS_OFF_CMD      8'h14
`define SDSS_E1_TRIG      13
`define SDSS_E1_PRE       16
`define SDSS_E1_POL       19
`define SDSS_E1_POST      20
`define SDSS_E1_SEL       23
`define SDSS_E2_FILT      15
`define SDSS_E2_IRQEN     19
`define SDSS_MD_WAIT      12
`define SDSS_ST_WIND      0
`define SDSS_ST_SHARED    23
`define SDSS_ST_CODE      24
`define SDSS_ST_LINE      29
`define SDSS_IRQ_SYNC     9
`define SDSS_CMD_START    8'h01
`define SDSS_CMD_SYNC     8'h12
`define SDSS_CMD_STOP     8'h32
`define SDSS_CFG_RST      14'h0000
`endif

// File: inc/sdss_pkg.sv
// Purpose: types of the stepper drive and sync start block
// Assumes: constants come from sdss_params.svh
// Notes: state codes are one-hot
`default_nettype none
package sdss_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, // reduction on, no motion
    ST_WAIT = 5'h02, // held for the sync line
    ST_PRE  = 5'h04, // reduction released, pre-run wait
    ST_RUN  = 5'h08, // motion in progress
    ST_POST = 5'h10  // post-run wait
  } sdss_state_e;
  typedef struct packed {
    logic       sel;
    logic       pol;
    logic [2:0] pre;
    logic [2:0] post;
    logic       trig_edge;
    logic       filt_long;
    logic       irq_en;
    logic       wait_sync;
    logic [1:0] spare;
  } sdss_cfg_s;
endpackage
`default_nettype wire

// File: design/sdss_top.sv
// Purpose: current reduction, winding phases and sync start of one axis
// Assumes: pulse_step, pulse_dir, operation_done, deviation_clear_in on hclk
// Notes: zero-wait AHB-Lite slave, whole words only
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`include "sdss_params.svh"
`timescale 1ns/1ps
`default_nettype none
module sdss_top #(
  parameter int unsigned CYC_1M6   = `SDSS_CYC(`SDSS_T_1M6_NS),   // 1.6 ms
  parameter int unsigned CYC_13M   = `SDSS_CYC(`SDSS_T_13M_NS),   // 13 ms
  parameter int unsigned CYC_52M   = `SDSS_CYC(`SDSS_T_52M_NS),   // 52 ms
  parameter int unsigned CYC_104M  = `SDSS_CYC(`SDSS_T_104M_NS),  // 104 ms
  parameter int unsigned CYC_208M  = `SDSS_CYC(`SDSS_T_208M_NS),  // 208 ms
  parameter int unsigned CYC_416M  = `SDSS_CYC(`SDSS_T_416M_NS),  // 416 ms
  parameter int unsigned CYC_832M  = `SDSS_CYC(`SDSS_T_832M_NS),  // 832 ms
  parameter int unsigned CYC_FLT_L = `SDSS_CYC(`SDSS_T_FLT_L_NS)  // 40 ms
) (
  input  wire logic        hclk,                   // clock
  input  wire logic        hresetn,                // async reset, low
  input  wire logic        ce,                     // clock enable
  input  wire logic        hsel,                   // slave select
  input  wire logic [31:0] haddr,                  // address
  input  wire logic [1:0]  htrans,                 // transfer type
  input  wire logic        hwrite,                 // write
  input  wire logic [2:0]  hsize,                  // size, words only
  input  wire logic [31:0] hwdata,                 // write data
  input  wire logic        hready,                 // bus ready
  output logic             hreadyout,              // always ready
  output logic             hresp,                  // always okay
  output logic [31:0]      hrdata,                 // read data
  input  wire logic        sync_begin_in,          // sync line level
  output logic             sync_begin_out,         // sync line drive value
  output logic             sync_begin_oe,          // pulling the line low
  input  wire logic        excitation_mode_select, // 0 2-2, 1 1-2
  input  wire logic        drive_topology_select,  // 0 unipolar, 1 bipolar
  input  wire logic        pulse_step,             // command pulse
  input  wire logic        pulse_dir,              // 1 positive
  input  wire logic        operation_done,         // motion finished
  input  wire logic        deviation_clear_in,     // clear signal level
  output logic             shared_out,             // shared output pin
  output logic             winding_a_drive,        // phase a
  output logic             winding_b_drive,        // phase b
  output logic             winding_c_drive,        // phase c
  output logic             winding_d_drive,        // phase d
  output logic             motion_start,           // start pulse
  output logic             run_active,             // motion running
  output logic             sync_irq                // interrupt, high
);
  localparam logic [15:0] UNI22 = {4'h3, 4'h6, 4'hC, 4'h9};
  localparam logic [31:0] UNI12 = {4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8, 4'h9};
  localparam logic [15:0] BIP22 = {4'h0, 4'h4, 4'hC, 4'h8};
  localparam logic [31:0] BIP12 = {4'h2, 4'h0, 4'h5, 4'h4, 4'hE, 4'hC, 4'h9, 4'h8};

  sdss_pkg::sdss_cfg_s   cfg_r, cfg_nxt;
  sdss_pkg::sdss_state_e st_r, st_nxt;
  logic                  wr_pend_r, wr_pend_nxt;
  logic [7:0]            wr_off_r, wr_off_nxt;
  logic [31:0]           rdata_r, rdata_nxt;
  logic                  irq_flag_r, irq_flag_nxt;
  logic                  take, addr_ok, clr, cmd_start, cmd_sync, cmd_stop;
  logic [23:0]           tmr_r, tmr_nxt, pend_n;
  logic                  go_r, go_nxt, shared_r, shared_nxt;
  logic                  hold_off, trig_fire, reduce;
  logic [3:0]            code;
  logic [2:0]            meta_r, sync_r;
  logic                  filt_r, filt_nxt, line_on, line_fall;
  logic [23:0]           fcnt_r, fcnt_nxt, thr;
  logic [3:0]            shot_r, shot_nxt;
  logic                  oe_r, oe_nxt;
  logic [2:0]            idx_r, idx_nxt;
  logic [3:0]            wind_r, wind_nxt;

  // cycles of pre-run wait per code
  function automatic logic [23:0] pre_cyc(input logic [2:0] c);
    logic [23:0] n;
    n = 24'h000001;
    unique case (c)
      3'b000: n = 24'(`SDSS_CYC(`SDSS_T_12U_NS));
      3'b001: n = 24'(`SDSS_CYC(`SDSS_T_102U_NS));
      3'b010: n = 24'(`SDSS_CYC(`SDSS_T_409U_NS));
      3'b011: n = 24'(CYC_1M6);
      3'b100: n = 24'(CYC_13M);
      3'b101: n = 24'(CYC_52M);
      3'b110: n = 24'(CYC_104M);
      3'b111: n = 24'h000001;
    endcase
    return n;
  endfunction

  // cycles of post-run wait per code, zero for none
  function automatic logic [23:0] post_cyc(input logic [2:0] c);
    logic [23:0] n;
    n = 24'h000000;
    unique case (c)
      3'b000: n = 24'h000000;
      3'b001: n = 24'(`SDSS_CYC(`SDSS_T_12U_NS));
      3'b010: n = 24'(CYC_1M6);
      3'b011: n = 24'(CYC_52M);
      3'b100: n = 24'(CYC_104M);
      3'b101: n = 24'(CYC_208M);
      3'b110: n = 24'(CYC_416M);
      3'b111: n = 24'(CYC_832M);
    endcase
    return n;
  endfunction

  // winding pattern {a,b,c,d} for a step index
  function automatic logic [3:0] phase_pat(input logic [2:0] i, input logic half, input logic bip);
    logic [3:0] p;
    p = 4'h0;
    unique case ({bip, half})
      2'b00: p = UNI22[{i[1:0], 2'b00} +: 4];
      2'b01: p = UNI12[{i, 2'b00} +: 4];
      2'b10: p = BIP22[{i[1:0], 2'b00} +: 4];
      2'b11: p = BIP12[{i, 2'b00} +: 4];
    endcase
    return p;
  endfunction

  // bus decode, config writes, commands, interrupt flag
  always_comb
  begin
    take = hsel && hready && htrans[1];
    addr_ok = (haddr[31:8] == 24'h000000);
    wr_pend_nxt = take && hwrite && addr_ok;
    wr_off_nxt = haddr[7:0];
    rdata_nxt = rdata_r;
    if (take && !hwrite)
    begin
      rdata_nxt = 32'h00000000;
      if (addr_ok)
        case (haddr[7:0])
          `SDSS_OFF_ENV1:
          begin
            rdata_nxt[`SDSS_E1_TRIG] = cfg_r.trig_edge;
            rdata_nxt[`SDSS_E1_PRE +: 3] = cfg_r.pre;
            rdata_nxt[`SDSS_E1_POL] = cfg_r.pol;
            rdata_nxt[`SDSS_E1_POST +: 3] = cfg_r.post;
            rdata_nxt[`SDSS_E1_SEL] = cfg_r.sel;
          end
          `SDSS_OFF_ENV2:
          begin
            rdata_nxt[`SDSS_E2_FILT] = cfg_r.filt_long;
            rdata_nxt[`SDSS_E2_IRQEN] = cfg_r.irq_en;
          end
          `SDSS_OFF_MODE: rdata_nxt[`SDSS_MD_WAIT] = cfg_r.wait_sync;
          `SDSS_OFF_STAT:
          begin
            rdata_nxt[`SDSS_ST_WIND +: 4] = wind_r;
            rdata_nxt[`SDSS_ST_SHARED] = shared_r;
            rdata_nxt[`SDSS_ST_CODE +: 4] = code;
            rdata_nxt[`SDSS_ST_LINE] = line_on;
          end
          `SDSS_OFF_IRQ: rdata_nxt[`SDSS_IRQ_SYNC] = irq_flag_r;
          default: rdata_nxt = 32'h00000000;
        endcase
    end
    cfg_nxt = cfg_r;
    clr = 1'b0;
    cmd_start = 1'b0;
    cmd_sync = 1'b0;
    cmd_stop = 1'b0;
    if (wr_pend_r)
      case (wr_off_r)
        `SDSS_OFF_ENV1:
        begin
          cfg_nxt.trig_edge = hwdata[`SDSS_E1_TRIG];
          cfg_nxt.pre = hwdata[`SDSS_E1_PRE +: 3];
          cfg_nxt.pol = hwdata[`SDSS_E1_POL];
          cfg_nxt.post = hwdata[`SDSS_E1_POST +: 3];
          cfg_nxt.sel = hwdata[`SDSS_E1_SEL];
        end
        `SDSS_OFF_ENV2:
        begin
          cfg_nxt.filt_long = hwdata[`SDSS_E2_FILT];
          cfg_nxt.irq_en = hwdata[`SDSS_E2_IRQEN];
        end
        `SDSS_OFF_MODE: cfg_nxt.wait_sync = hwdata[`SDSS_MD_WAIT];
        `SDSS_OFF_IRQ: clr = hwdata[`SDSS_IRQ_SYNC];
        `SDSS_OFF_CMD:
        begin
          cmd_start = (hwdata[7:0] == `SDSS_CMD_START);
          cmd_sync = (hwdata[7:0] == `SDSS_CMD_SYNC);
          cmd_stop = (hwdata[7:0] == `SDSS_CMD_STOP);
        end
        default: cfg_nxt = cfg_r;
      endcase
    // a new line event wins over a clear in the same cycle
    irq_flag_nxt = (line_fall && cfg_r.irq_en) || (irq_flag_r && !clr);
  end

  // bus and config registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_r <= `SDSS_CFG_RST;
      wr_pend_r <= 1'b0;
      wr_off_r <= 8'h00;
      rdata_r <= 32'h00000000;
      irq_flag_r <= 1'b0;
    end
    else if (ce)
    begin
      cfg_r <= cfg_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_off_r <= wr_off_nxt;
      rdata_r <= rdata_nxt;
      irq_flag_r <= irq_flag_nxt;
    end
  end

  // pin synchronisers: sync line, excitation, topology
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_r <= 3'b001;
      sync_r <= 3'b001;
    end
    else if (ce)
    begin
      meta_r <= {drive_topology_select, excitation_mode_select, sync_begin_in};
      sync_r <= meta_r;
    end
  end

  // pulse filter on the line and the outgoing one-shot
  always_comb
  begin
    thr = cfg_r.filt_long ? 24'(CYC_FLT_L) : 24'(`SDSS_CYC(`SDSS_T_FLT_S_NS));
    filt_nxt = filt_r;
    fcnt_nxt = 24'h000000;
    if (sync_r[0] != filt_r)
    begin
      if (fcnt_r >= thr - 24'h000001)
        filt_nxt = sync_r[0];
      else
        fcnt_nxt = fcnt_r + 24'h000001;
    end
    line_on = !filt_r;
    line_fall = filt_r && !filt_nxt;
    shot_nxt = (shot_r != 4'h0) ? shot_r - 4'h1 : 4'h0;
    if (cmd_sync)
      shot_nxt = `SDSS_SHOT_CYC;
    oe_nxt = (shot_nxt != 4'h0);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filt_r <= 1'b1;
      fcnt_r <= 24'h000000;
      shot_r <= 4'h0;
      oe_r <= 1'b0;
    end
    else if (ce)
    begin
      filt_r <= filt_nxt;
      fcnt_r <= fcnt_nxt;
      shot_r <= shot_nxt;
      oe_r <= oe_nxt;
    end
  end

  // axis sequence: wait, pre-run, run, post-run
  always_comb
  begin
    st_nxt = st_r;
    tmr_nxt = (tmr_r != 24'h000000) ? tmr_r - 24'h000001 : tmr_r;
    go_nxt = 1'b0;
    pend_n = post_cyc(cfg_r.post);
    hold_off = cfg_r.wait_sync && !(line_on && !cfg_r.trig_edge);
    trig_fire = cfg_r.trig_edge ? line_fall : line_on;
    unique case (st_r)
      sdss_pkg::ST_IDLE:
        if (cmd_start && hold_off)
          st_nxt = sdss_pkg::ST_WAIT;
      sdss_pkg::ST_WAIT: st_nxt = st_r;
      sdss_pkg::ST_PRE:
        if (tmr_r == 24'h000000)
        begin
          st_nxt = sdss_pkg::ST_RUN;
          go_nxt = 1'b1;
        end
      sdss_pkg::ST_RUN:
        if (operation_done)
        begin
          st_nxt = (pend_n == 24'h000000) ? sdss_pkg::ST_IDLE : sdss_pkg::ST_POST;
          tmr_nxt = pend_n - 24'h000001;
        end
      sdss_pkg::ST_POST:
        if (tmr_r == 24'h000000)
          st_nxt = sdss_pkg::ST_IDLE;
    endcase
    if ((st_r == sdss_pkg::ST_IDLE && cmd_start && !hold_off) ||
        (st_r == sdss_pkg::ST_WAIT && trig_fire))
    begin
      st_nxt = sdss_pkg::ST_PRE;
      tmr_nxt = pre_cyc(cfg_r.pre) - 24'h000001;
    end
    if (cmd_stop)
      st_nxt = sdss_pkg::ST_IDLE;
    reduce = (st_nxt == sdss_pkg::ST_IDLE) || (st_nxt == sdss_pkg::ST_WAIT);
    shared_nxt = cfg_nxt.sel ? (cfg_nxt.pol ? reduce : !reduce) : deviation_clear_in;
    code = 4'h0;
    unique case (st_r)
      sdss_pkg::ST_IDLE: code = 4'h0;
      sdss_pkg::ST_WAIT: code = 4'hC;
      sdss_pkg::ST_PRE:  code = 4'h2;
      sdss_pkg::ST_RUN:  code = 4'h1;
      sdss_pkg::ST_POST: code = 4'h3;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= sdss_pkg::ST_IDLE;
      tmr_r <= 24'h000000;
      go_r <= 1'b0;
      shared_r <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      go_r <= go_nxt;
      shared_r <= shared_nxt;
    end
  end

  // step index follows command pulses, pattern from selects
  always_comb
  begin
    idx_nxt = idx_r;
    if (pulse_step)
      idx_nxt = pulse_dir ? idx_r + 3'h1 : idx_r - 3'h1;
    wind_nxt = phase_pat(idx_nxt, sync_r[1], sync_r[2]);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      idx_r <= 3'h0;
      wind_r <= 4'h9;
    end
    else if (ce)
    begin
      idx_r <= idx_nxt;
      wind_r <= wind_nxt;
    end
  end

  // outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign sync_begin_out = 1'b0;
  assign sync_begin_oe = oe_r;
  assign shared_out = shared_r;
  assign {winding_a_drive, winding_b_drive, winding_c_drive, winding_d_drive} = wind_r;
  assign motion_start = go_r;
  assign run_active = st_r[3];
  assign sync_irq = irq_flag_r;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !ce);

  sequence s_shot;
    (sync_begin_oe && !sync_begin_out)[*8];
  endsequence
  property p_sync_shot;
    cmd_sync && !sync_begin_oe |=> s_shot ##1 !sync_begin_oe;
  endproperty
  a_sync_shot: assert property (p_sync_shot)
    else $error("sync one-shot length wrong");

  property p_wait_enter;
    st_r == sdss_pkg::ST_IDLE && cmd_start && cfg_r.wait_sync && !line_on |=> st_r == sdss_pkg::ST_WAIT;
  endproperty
  a_wait_enter: assert property (p_wait_enter)
    else $error("start with wait bit did not wait");

  property p_wait_code;
    take && !hwrite && addr_ok && haddr[7:0] == `SDSS_OFF_STAT && st_r == sdss_pkg::ST_WAIT
      |=> hrdata[`SDSS_ST_CODE +: 4] == 4'hC;
  endproperty
  a_wait_code: assert property (p_wait_code)
    else $error("waiting state code wrong");

  property p_stop;
    cmd_stop |=> st_r == sdss_pkg::ST_IDLE && !sync_begin_out;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not return to idle");

  property p_level_now;
    st_r == sdss_pkg::ST_IDLE && cmd_start && cfg_r.wait_sync && !cfg_r.trig_edge && line_on
      |=> st_r == sdss_pkg::ST_PRE;
  endproperty
  a_level_now: assert property (p_level_now)
    else $error("level trigger did not start at once");

  sequence s_pre_go;
    ##120 motion_start;
  endsequence
  property p_pre_12us;
    st_r == sdss_pkg::ST_IDLE && cmd_start && !cfg_r.wait_sync && cfg_r.pre == 3'b000 |=> s_pre_go;
  endproperty
  a_pre_12us: assert property (p_pre_12us)
    else $error("pre-run wait not 120 cycles");

  property p_post_zero;
    st_r == sdss_pkg::ST_RUN && operation_done && cfg_r.post == 3'b000 && !cmd_stop
      |=> st_r == sdss_pkg::ST_IDLE;
  endproperty
  a_post_zero: assert property (p_post_zero)
    else $error("zero post-run wait not immediate");

  property p_cdw;
    cfg_r.sel |-> shared_out == ((st_r == sdss_pkg::ST_IDLE || st_r == sdss_pkg::ST_WAIT) ? cfg_r.pol : !cfg_r.pol);
  endproperty
  a_cdw: assert property (p_cdw)
    else $error("reduction output level wrong");

  property p_irq;
    line_fall && cfg_r.irq_en |=> sync_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("line event did not raise interrupt");

  property p_filter;
    !cfg_r.filt_long && line_fall |-> !$past(sync_r[0], 4) && !$past(sync_r[0], 2);
  endproperty
  a_filter: assert property (p_filter)
    else $error("short sync pulse accepted");
endmodule
`default_nettype wire

// File: tb/sdss_peer_model.sv
// Purpose: peer controller on the wired sync line
// Assumes: open-collector line with a pull-up
// Notes: a peer pulse lasts hold_len cycles of hclk
`timescale 1ns/1ps
`default_nettype none
module sdss_peer_model (
  input  wire logic        hclk,     // clock
  input  wire logic        hresetn,  // reset, low
  input  wire logic        dut_oe,   // device sinks the line
  input  wire logic        go,       // start a peer pulse
  input  wire logic [15:0] hold_len, // pulse length in cycles
  output logic             line      // wired line level
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  // peer pulse length, bench picks it long or short
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (go)
      cnt_nxt = hold_len;
    else if (cnt_r != 16'h0000)
      cnt_nxt = cnt_r - 16'h0001;
  end
  // count register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_r <= 16'h0000;
    else
      cnt_r <= cnt_nxt;
  end
  // pull-up wins unless a party sinks the line
  assign line = ~(dut_oe | (cnt_r != 16'h0000));
endmodule
`default_nettype wire

// File: tb/stepper_drive_and_sync_start_test.sv
// Purpose: self-checking bench of sdss_top
// Assumes: 10 MHz hclk, shortened delay counts
// Notes: the peer model owns the wired sync line
`timescale 1ns/1ps
`default_nettype none
module stepper_drive_and_sync_start_test;
  logic             hclk, hresetn, hsel, hwrite, exc, top, pstep, pdir, odone, dclr, go, st, ce;
  logic [1:0]       htrans;
  logic [15:0]      hold;
  logic [31:0]      haddr, hwdata, rd;
  logic [2:0]       idx, hsz;
  wire logic [31:0] hrdata;
  wire logic        hready, oe, line, sh, wa, wb, wc, wd, mst, run, irq, rsp, sbo;
  int               n_fail, compares, cyc, n;
  // shortened delay counts, shared by the instance and the expectations
  localparam int    c_1m6 = 20, c_13m = 30, c_52m = 40, c_104m = 50, c_208m = 60, c_416m = 70, c_832m = 80;
  localparam int    c_flt_l = 12;
  int               pre_t[8] = '{120, 1020, 4090, c_1m6, c_13m, c_52m, c_104m, 1};
  int               post_t[8] = '{0, 120, c_1m6, c_52m, c_104m, c_208m, c_416m, c_832m};
  logic [3:0]       pt[4][8] = '{'{4'h9, 4'hC, 4'h6, 4'h3, 4'h9, 4'hC, 4'h6, 4'h3},
    '{4'h9, 4'h8, 4'hC, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1}, '{4'h8, 4'hC, 4'h4, 4'h0, 4'h8, 4'hC, 4'h4, 4'h0},
    '{4'h8, 4'h9, 4'hC, 4'hE, 4'h4, 4'h5, 4'h0, 4'h2}};

  sdss_top #(.CYC_1M6(c_1m6), .CYC_13M(c_13m), .CYC_52M(c_52m), .CYC_104M(c_104m), .CYC_208M(c_208m),
    .CYC_416M(c_416m), .CYC_832M(c_832m), .CYC_FLT_L(c_flt_l)) dut (.hclk(hclk), .hresetn(hresetn),
    .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsz), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(rsp), .hrdata(hrdata), .sync_begin_in(line), .sync_begin_out(sbo),
    .sync_begin_oe(oe), .excitation_mode_select(exc), .drive_topology_select(top), .pulse_step(pstep),
    .pulse_dir(pdir), .operation_done(odone), .deviation_clear_in(dclr), .shared_out(sh),
    .winding_a_drive(wa), .winding_b_drive(wb), .winding_c_drive(wc), .winding_d_drive(wd),
    .motion_start(mst), .run_active(run), .sync_irq(irq));
  sdss_peer_model peer (.hclk(hclk), .hresetn(hresetn), .dut_oe(oe), .go(go), .hold_len(hold), .line(line));

  function automatic logic [31:0] env1(logic t, logic [2:0] pr, logic p, logic [2:0] po, logic s);
    return {8'h00, s, po, p, pr, 2'b00, t, 13'h0000};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single-word transfer, read data kept in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hsize_set: hsz <= 3'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task pulse_peer(input logic [15:0] len);
    hold <= len;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
  endtask
  task done_op;
    odone <= 1'b1;
    @(posedge hclk);
    odone <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  task reset_and_shared;
    bus(1'b0, 8'h0C, 32'h0);
    check(rd[3:0], 4'h9);
    check(rd[27:24], 4'h0);
    bus(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0);
    dclr <= 1'b1;
    repeat (3) @(posedge hclk);
    check(sh, 1'b1);
    bus(1'b1, 8'h00, env1(1'b0, 3'h0, 1'b0, 3'h0, 1'b1));
    repeat (2) @(posedge hclk);
    check(sh, 1'b0);
    bus(1'b1, 8'h00, env1(1'b0, 3'h0, 1'b1, 3'h0, 1'b1));
    bus(1'b0, 8'h0C, 32'h0);
    check(rd[23], 1'b1);
    bus(1'b0, 8'h00, 32'h0);
    check(rd, env1(1'b0, 3'h0, 1'b1, 3'h0, 1'b1));
    dclr <= 1'b0;
    $display("test reset_and_shared done");
  endtask
  task windings;
    for (int m = 0; m < 4; m++)
    begin
      exc <= m[0];
      top <= m[1];
      repeat (4) @(posedge hclk);
      for (int k = 0; k < 10; k++)
      begin
        pdir <= (k < 8);
        pstep <= 1'b1;
        @(posedge hclk);
        pstep <= 1'b0;
        idx = (k < 8) ? idx + 3'h1 : idx - 3'h1;
        @(posedge hclk);
        check({wa, wb, wc, wd}, pt[m][idx]);
      end
    end
    // a step pulse while the clock enable is low must leave the phases frozen
    ce <= 1'b0;
    pstep <= 1'b1;
    repeat (2) @(posedge hclk);
    pstep <= 1'b0;
    ce <= 1'b1;
    check({wa, wb, wc, wd}, pt[3][idx]);
    bus(1'b0, 8'h0C, 32'h0);
    check(rd[3:0], pt[3][idx]);
    $display("test windings done");
  endtask
  // start without sync wait, time pre-run and post-run delays
  task run_motion(input logic [2:0] c);
    bus(1'b1, 8'h00, env1(1'b0, c, 1'b1, c, 1'b1));
    bus(1'b1, 8'h14, 32'h01);
    n = 0;
    while (mst !== 1'b1 && n < 5000)
    begin
      @(posedge hclk);
      n++;
    end
    check(32'(n + 2 >= pre_t[c] && n <= pre_t[c] + 2), 1);
    check({run, sh}, 2'b10);
    odone <= 1'b1;
    @(posedge hclk);
    odone <= 1'b0;
    n = 0;
    while (sh !== 1'b1 && n < 500)
    begin
      @(posedge hclk);
      n++;
    end
    check(32'(n + 2 >= post_t[c] && n <= post_t[c] + 2), 1);
  endtask
  task sync_cmd;
    bus(1'b1, 8'h04, 32'h00080000);
    bus(1'b1, 8'h00, env1(1'b1, 3'h7, 1'b0, 3'h0, 1'b1));
    bus(1'b1, 8'h08, 32'h00001000);
    bus(1'b0, 8'h04, 32'h0);
    check(rd, 32'h00080000);
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h00001000);
    bus(1'b1, 8'h14, 32'h01);
    bus(1'b0, 8'h0C, 32'h0);
    check(rd[27:24], 4'hC);
    bus(1'b1, 8'h14, 32'h12);
    n = 0;
    st = 1'b0;
    repeat (30)
    begin
      @(posedge hclk);
      if (oe === 1'b1)
        n++;
      if (mst === 1'b1)
        st = 1'b1;
    end
    check(n, 8);
    check({rsp, sbo}, 2'b00);
    check(st, 1'b1);
    check(irq, 1'b1);
    done_op();
    bus(1'b0, 8'h10, 32'h0);
    check(rd[9], 1'b1);
    bus(1'b1, 8'h10, 32'h00000200);
    bus(1'b0, 8'h10, 32'h0);
    check({rd[9], irq}, 2'b00);
    $display("test sync_cmd done");
  endtask
  task filt_stop;
    bus(1'b1, 8'h14, 32'h01);
    for (int k = 0; k < 2; k++)
    begin
      bus(1'b1, 8'h04, {16'h0000, k[0], 15'h0000});
      pulse_peer(k ? 16'h0008 : 16'h0003);
      repeat (25) @(posedge hclk);
      bus(1'b0, 8'h0C, 32'h0);
      check(rd[27:24], 4'hC);
    end
    bus(1'b1, 8'h14, 32'h32);
    bus(1'b0, 8'h0C, 32'h0);
    check(rd[27:24], 4'h0);
    bus(1'b1, 8'h00, env1(1'b0, 3'h7, 1'b0, 3'h0, 1'b1));
    pulse_peer(16'h012C);
    repeat (20) @(posedge hclk);
    bus(1'b0, 8'h0C, 32'h0);
    check(rd[29], 1'b1);
    bus(1'b1, 8'h14, 32'h01);
    st = 1'b0;
    repeat (10)
    begin
      @(posedge hclk);
      if (mst === 1'b1)
        st = 1'b1;
    end
    check(st, 1'b1);
    done_op();
    repeat (300) @(posedge hclk);
    bus(1'b0, 8'h0C, 32'h0);
    check(rd[29], 1'b0);
    $display("test filt_stop done");
  endtask
  task tally_and_finish;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // clock, 100 ns period
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  // main sequence
  initial
  begin
    {hresetn, hsel, hwrite, exc, top, pstep, pdir, odone, dclr, go} = 10'h0;
    {htrans, hold, haddr, hwdata, idx, hsz} = 88'h0;
    ce = 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_and_shared();
    windings();
    for (int c = 0; c < 8; c++)
      run_motion(c[2:0]);
    $display("test run_motion done");
    sync_cmd();
    filt_stop();
    tally_and_finish();
  end
endmodule
`default_nettype wire
